// ==== verilog/vsbm_mapper.sv ====
// Purpose: Symbol mapper with sync insertion, field sync build and pilot offset.
// Assumes: Static mode and enhancement inputs from logic on core_clk.
// Notes: Output level is signed with two fractional bits (quarters).
`timescale 1ns/1ns
// Behaviour
// - Enhancement bits undefined for the chosen context are sent as zero.
// - With enhancements off, context zero and all enhancement bits zero.
// - Several enhancement bits may be set together in one context.
// - Eight-level data maps to odd levels minus seven to plus seven.
// - Eight-level sync symbols sit at minus five or plus five.
// - Eight-level mode adds 1.25 to every symbol.
// - Symbols leave at a nominal 10.76 million per second.
// - Sixteen-level mode bypasses trellis coding with a direct mapper.
// - Sixteen-level segment carries two 207-byte groups, two symbols per byte.
// - Sixteen-level data bytes pass a 26-segment convolutional interleaver.
// - Sixteen-level data maps to odd levels minus fifteen to plus fifteen.
// - Sixteen-level sync symbols sit at minus nine or plus nine.
// - Sixteen-level mode adds 2.5 to every symbol.
// - Segment and field timing are the same in both modes.
// - Enhancement zero is low in odd fields, high in even ones.
// - Context bits in symbols 810 and 811, enhancement bits follow.
// - Each 832-symbol segment starts with plus, minus, minus, plus.
module vsbm_mapper
   import vsbm_pkg::*;
#(
   parameter int CLK_RATE_KHZ = CLK_KHZ,
   parameter int SYM_RATE_KHZ = SYM_KHZ,
   parameter logic [31:0] ENH_MASKS = ENH_DEF_MASKS,
   parameter int BRANCHES = ILV_BRANCHES,
   parameter int UNIT = ILV_UNIT
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic mode_16,
   input wire logic enh_on,
   input wire logic [1:0] ctx_num,
   input wire logic [7:0] enh_bits,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   output logic in_ready,
   output logic out_valid,
   input wire logic out_ready,
   output logic [LVL_W-1:0] out_level,
   output logic out_sync,
   output logic out_seg_start,
   output logic out_field_start,
   output logic field_odd
);
   localparam int BUF_W = LVL_W + 3;
   typedef struct packed {
      vsbm_region_e region;
      logic [9:0] sym;
      logic [8:0] seg;
      logic odd;
      logic [8:0] pn511;
      logic [5:0] srun;
      logic [15:0] acc;
      logic tick;
      logic [7:0] hold;
      logic hold_v;
      logic in_rdy;
      logic [3:0] nib;
      logic [PRE_LEN-1:0][NOM_W-1:0] hist;
   } vsbm_map_s;

   vsbm_map_s s_reg;
   vsbm_map_s s_next;
   logic [15:0] acc_sum;
   logic wrap;
   logic need;
   logic step;
   logic ilv_step;
   logic bit_v;
   logic use_bit;
   logic sync_f;
   logic [9:0] sub;
   logic [4:0] mix;
   logic [23:0] mword;
   logic [NOM_W-1:0] nom;
   logic [LVL_W-1:0] level;
   logic [1:0] ctx_eff;
   logic [7:0] enh_eff;
   logic [ENH_SIG_LEN-1:0] sig;
   logic [7:0] ilv_dout;
   logic buf_in_ready;
   logic [BUF_W-1:0] buf_in_data;
   logic [BUF_W-1:0] buf_out_data;

   function automatic logic [NOM_W-1:0] bin_level(input logic b, input logic m16);
      logic [NOM_W-1:0] mag;
      mag = m16 ? SYNC16 : SYNC8;
      return b ? mag : -mag;
   endfunction

   function automatic logic [LVL_W-1:0] to_q(input logic [NOM_W-1:0] n, input logic m16);
      return {n, {FRAC_W{1'b0}}} + (m16 ? PILOT16 : PILOT8);
   endfunction

   assign in_ready = s_reg.in_rdy;
   assign field_odd = s_reg.odd;
   assign out_level = buf_out_data[LVL_W-1:0];
   assign out_field_start = buf_out_data[LVL_W];
   assign out_seg_start = buf_out_data[LVL_W+1];
   assign out_sync = buf_out_data[LVL_W+2];

   assign ctx_eff = enh_on ? ctx_num : 2'h0;
   assign enh_eff = enh_on ? (enh_bits & ENH_MASKS[{ctx_eff, 3'h0} +: 8]) : 8'h00;
   assign sig = {enh_eff, ctx_eff[0], ctx_eff[1]};

   always_comb begin
      s_next = s_reg;
      wrap = 1'b0;
      ilv_step = 1'b0;
      bit_v = 1'b0;
      use_bit = 1'b1;
      sync_f = 1'b1;
      sub = '0;
      mix = '0;
      mword = mode_16 ? MODE_WORD16 : MODE_WORD8;
      nom = '0;
      // Fractional pacing of the symbol rate.
      acc_sum = s_reg.acc + 16'(SYM_RATE_KHZ);
      if (acc_sum >= 16'(CLK_RATE_KHZ)) begin
         s_next.acc = acc_sum - 16'(CLK_RATE_KHZ);
         wrap = 1'b1;
      end else begin
         s_next.acc = acc_sum;
      end
      need = (s_reg.region == RG_DATA) && (!mode_16 || !s_reg.sym[0]);
      step = s_reg.tick && buf_in_ready && (!need || s_reg.hold_v);
      // A symbol slot missed by a stall is kept, so one backlog slot is caught up.
      s_next.tick = wrap || (s_reg.tick && !step);

      case (s_reg.region)
         RG_SSYNC: begin
            bit_v = s_reg.sym[0] ~^ s_reg.sym[1];
         end
         RG_PN511: begin
            bit_v = s_reg.pn511[0];
         end
         RG_SRUN: begin
            bit_v = s_reg.srun[0] ^
               (!s_reg.odd && s_reg.sym >= P_SRUNB && s_reg.sym < P_SRUNC);
         end
         RG_MODE: begin
            sub = s_reg.sym - P_MODE;
            mix = 5'(MODE_LEN - 1) - sub[4:0];
            bit_v = mword[mix];
         end
         RG_RESV: begin
            if (s_reg.sym < P_CTX) begin
               bit_v = s_reg.srun[0];
            end else begin
               sub = s_reg.sym - P_CTX;
               bit_v = sig[sub[3:0]] ^ !s_reg.odd;
            end
         end
         RG_PRE: begin
            use_bit = 1'b0;
            sync_f = 1'b0;
            sub = s_reg.sym - P_PRE;
            // History keeps bit 0 inverted, so a cleared entry still reads as an odd level.
            nom = {s_reg.hist[sub[3:0]][NOM_W-1:1], ~s_reg.hist[sub[3:0]][0]};
         end
         RG_DATA: begin
            use_bit = 1'b0;
            sync_f = 1'b0;
            if (!mode_16) begin
               nom = {2'h0, s_reg.hold[2:0], 1'b0} - BIAS8;
            end else if (!s_reg.sym[0]) begin
               nom = {1'b0, ilv_dout[7:4], 1'b0} - BIAS16;
            end else begin
               nom = {1'b0, s_reg.nib, 1'b0} - BIAS16;
            end
         end
         default: begin
            bit_v = 1'b0;
         end
      endcase
      if (use_bit) begin
         nom = bin_level(bit_v, mode_16);
      end
      level = to_q(nom, mode_16);

      if (s_reg.region != RG_PN511) begin
         s_next.pn511 = PN511_INIT;
      end else if (step) begin
         s_next.pn511 = {s_reg.pn511[7] ^ s_reg.pn511[6] ^ s_reg.pn511[4] ^
            s_reg.pn511[3] ^ s_reg.pn511[1] ^ s_reg.pn511[0], s_reg.pn511[8:1]};
      end

      if (step) begin
         if (s_reg.sym == P_SRUNA - 1'b1 || s_reg.sym == P_SRUNB - 1'b1 ||
            s_reg.sym == P_SRUNC - 1'b1) begin
            s_next.srun = SRUN_INIT;
         end else if (s_reg.region == RG_SRUN ||
            (s_reg.region == RG_RESV && s_reg.sym < P_CTX)) begin
            s_next.srun = {s_reg.srun[1] ^ s_reg.srun[0], s_reg.srun[5:1]};
         end
         if (s_reg.region == RG_DATA) begin
            s_next.hist = {{nom[NOM_W-1:1], ~nom[0]}, s_reg.hist[PRE_LEN-1:1]};
            // High nibble first, low nibble next.
            if (mode_16 && !s_reg.sym[0]) begin
               s_next.nib = ilv_dout[3:0];
               ilv_step = 1'b1;
            end
         end
         if (need) begin
            s_next.hold_v = 1'b0;
         end
         if (s_reg.sym == SEG_LAST) begin
            s_next.sym = '0;
            s_next.seg = (s_reg.seg == FIELD_LAST) ? '0 : s_reg.seg + 1'b1;
         end else begin
            s_next.sym = s_reg.sym + 1'b1;
         end
         if (s_reg.sym == '0 && s_reg.seg == '0) begin
            s_next.odd = !s_reg.odd;
         end
         case (s_reg.region)
            RG_SSYNC: begin
               if (s_reg.sym == SSYNC_LAST) begin
                  s_next.region = (s_reg.seg == '0) ? RG_PN511 : RG_DATA;
               end
            end
            RG_PN511: begin
               if (s_reg.sym == P_SRUNA - 1'b1) begin
                  s_next.region = RG_SRUN;
               end
            end
            RG_SRUN: begin
               if (s_reg.sym == P_MODE - 1'b1) begin
                  s_next.region = RG_MODE;
               end
            end
            RG_MODE: begin
               if (s_reg.sym == P_RESV - 1'b1) begin
                  s_next.region = RG_RESV;
               end
            end
            RG_RESV: begin
               if (s_reg.sym == P_PRE - 1'b1) begin
                  s_next.region = RG_PRE;
               end
            end
            RG_PRE, RG_DATA: begin
               if (s_reg.sym == SEG_LAST) begin
                  s_next.region = RG_SSYNC;
               end
            end
            default: begin
               s_next.region = RG_SSYNC;
            end
         endcase
      end

      if (s_reg.in_rdy && in_valid) begin
         s_next.hold = in_data;
         s_next.hold_v = 1'b1;
      end
      s_next.in_rdy = !s_next.hold_v;
   end

   assign buf_in_data = {sync_f, s_reg.sym == '0, s_reg.sym == '0 && s_reg.seg == '0, level};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   vsbm_byte_ilv #(
      .BRANCHES(BRANCHES),
      .UNIT(UNIT)
   ) u_ilv (
      .core_clk(core_clk),
      .rst(rst),
      .step(ilv_step),
      .din(s_reg.hold),
      .dout(ilv_dout)
   );

   vsbm_pair_buf #(
      .W(BUF_W)
   ) u_buf (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(step),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(buf_out_data)
   );

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   logic [LVL_W-1:0] off8;
   logic [LVL_W-1:0] off16;
   assign off8 = out_level - PILOT8;
   assign off16 = out_level - PILOT16;

   chk_seg_first: assert property (
      out_valid && out_seg_start |-> out_sync && out_level == to_q(bin_level(1'b1, mode_16), mode_16))
      else $error("segment does not open with a positive sync symbol");
   chk_sync_eight: assert property (
      out_valid && out_sync && !mode_16 |->
         out_level == to_q(SYNC8, 1'b0) || out_level == to_q(-SYNC8, 1'b0))
      else $error("eight-level sync symbol off its level");
   chk_sync_sixteen: assert property (
      out_valid && out_sync && mode_16 |->
         out_level == to_q(SYNC16, 1'b1) || out_level == to_q(-SYNC16, 1'b1))
      else $error("sixteen-level sync symbol off its level");
   chk_data_eight: assert property (
      out_valid && !out_sync && !mode_16 |-> off8[2:0] == 3'h4 &&
         $signed(off8) <= $signed(8'h1C) && $signed(off8) >= $signed(8'hE4))
      else $error("eight-level data level or pilot wrong");
   chk_data_sixteen: assert property (
      out_valid && !out_sync && mode_16 |-> off16[2:0] == 3'h4 &&
         $signed(off16) <= $signed(8'h3C) && $signed(off16) >= $signed(8'hC4))
      else $error("sixteen-level data level or pilot wrong");
   chk_field_toggle: assert property (
      step && s_reg.sym == '0 && s_reg.seg == '0 |=> field_odd != $past(field_odd))
      else $error("field parity did not flip at field sync");
   chk_ctx_idle: assert property (
      step && !enh_on && s_reg.region == RG_RESV && s_reg.sym >= P_CTX |->
         nom == bin_level(!s_reg.odd, mode_16))
      else $error("idle signalling symbol is not a zero bit");
   chk_ctx0_undef: assert property (
      step && enh_on && ctx_num == 2'h0 && ENH_MASKS[7:0] == 8'h00 &&
         s_reg.region == RG_RESV && s_reg.sym >= P_ENH |-> nom == bin_level(!s_reg.odd, mode_16))
      else $error("undefined enhancement bit sent as one");
   chk_ilv_data: assert property (
      ilv_step |-> s_reg.region == RG_DATA && mode_16 && step)
      else $error("interleaver stepped outside data");
   chk_rate_gap: assert property (
      wrap |=> !wrap ##1 !wrap ##1 !wrap)
      else $error("symbol slots closer than four clocks");
   chk_data_region: assert property (
      s_reg.region == RG_DATA |-> s_reg.seg != '0 && s_reg.sym > SSYNC_LAST)
      else $error("data region inside field sync or segment sync");

   cov_field_start: cover property (out_valid && out_ready && out_field_start);
   cov_sixteen_data: cover property (step && mode_16 && s_reg.region == RG_DATA);
   cov_stall: cover property (out_valid && !out_ready ##1 !buf_in_ready);
   cov_enh_sent: cover property (step && enh_on && s_reg.sym == P_ENH);
endmodule

// ==== common/vsbm_pkg.sv ====
// Purpose: Shared constants and types for the symbol mapper with pilot.
// Assumes: One symbol-rate pacing clock, levels in signed fixed point.
// Notes: Levels carry two fractional bits so both pilot offsets are exact.
package vsbm_pkg;
   localparam int SEG_SYMS = 832;
   localparam int FIELD_SEGS = 313;
   localparam int SSYNC_LEN = 4;
   localparam int PN511_LEN = 511;
   localparam int SRUN_LEN = 63;
   localparam int MODE_LEN = 24;
   localparam int RESV_LEN = 104;
   localparam int CTX_LEN = 2;
   localparam int ENH_SIG_LEN = 10;
   localparam int PRE_LEN = 12;
   localparam logic [9:0] SEG_LAST = 10'(SEG_SYMS - 1);
   localparam logic [9:0] SSYNC_LAST = 10'(SSYNC_LEN - 1);
   localparam logic [8:0] FIELD_LAST = 9'(FIELD_SEGS - 1);
   localparam logic [9:0] P_SRUNA = 10'(SSYNC_LEN + PN511_LEN);
   localparam logic [9:0] P_SRUNB = 10'(SSYNC_LEN + PN511_LEN + SRUN_LEN);
   localparam logic [9:0] P_SRUNC = 10'(SSYNC_LEN + PN511_LEN + 2 * SRUN_LEN);
   localparam logic [9:0] P_MODE = 10'(SSYNC_LEN + PN511_LEN + 3 * SRUN_LEN);
   localparam logic [9:0] P_RESV = 10'(SSYNC_LEN + PN511_LEN + 3 * SRUN_LEN + MODE_LEN);
   localparam logic [9:0] P_PRE = 10'(SEG_SYMS - PRE_LEN);
   localparam logic [9:0] P_CTX = 10'(SEG_SYMS - PRE_LEN - ENH_SIG_LEN);
   localparam logic [9:0] P_ENH = 10'(SEG_SYMS - PRE_LEN - ENH_SIG_LEN + CTX_LEN);
   localparam logic [8:0] PN511_INIT = 9'h080;
   localparam logic [5:0] SRUN_INIT = 6'h27;
   localparam logic [23:0] MODE_WORD8 = 24'h0A5F5A;
   localparam logic [23:0] MODE_WORD16 = 24'h0F0F3C;
   localparam int NOM_W = 6;
   localparam int FRAC_W = 2;
   localparam int LVL_W = 8;
   localparam logic [NOM_W-1:0] SYNC8 = 6'h05;
   localparam logic [NOM_W-1:0] SYNC16 = 6'h09;
   localparam logic [NOM_W-1:0] BIAS8 = 6'h07;
   localparam logic [NOM_W-1:0] BIAS16 = 6'h0F;
   localparam logic [LVL_W-1:0] PILOT8 = 8'h05;
   localparam logic [LVL_W-1:0] PILOT16 = 8'h0A;
   localparam int CLK_KHZ = 50000;
   localparam int SYM_KHZ = 10760;
   localparam int ILV_BRANCHES = 52;
   localparam int ILV_UNIT = 4;
   localparam logic [31:0] ENH_DEF_MASKS = 32'hFFFFFF00;
   typedef enum logic [2:0] {
      RG_SSYNC = 3'h0,
      RG_DATA = 3'h1,
      RG_PN511 = 3'h4,
      RG_SRUN = 3'h5,
      RG_MODE = 3'h7,
      RG_RESV = 3'h6,
      RG_PRE = 3'h2
   } vsbm_region_e;
endpackage

// ==== verilog/vsbm_pair_buf.sv ====
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Both sides on core_clk.
// Notes: A full buffer drops in_ready, so a stalled receiver loses no word.
`timescale 1ns/1ns
module vsbm_pair_buf
   import vsbm_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   typedef struct packed {
      logic [W-1:0] e1;
      logic [W-1:0] e0;
      logic v1;
      logic v0;
   } vsbm_buf_s;
   vsbm_buf_s s_reg;
   vsbm_buf_s s_next;

   assign in_ready = !s_reg.v1;
   assign out_valid = s_reg.v0;
   assign out_data = s_reg.e0;

   always_comb begin
      s_next = s_reg;
      if (s_reg.v0 && out_ready) begin
         s_next.e0 = s_reg.e1;
         s_next.v0 = s_reg.v1;
         s_next.v1 = 1'b0;
      end
      if (in_valid && !s_reg.v1) begin
         if (!s_next.v0) begin
            s_next.e0 = in_data;
            s_next.v0 = 1'b1;
         end else begin
            s_next.e1 = in_data;
            s_next.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// ==== verilog/vsbm_byte_ilv.sv ====
// Purpose: Convolutional byte interleaver for the sixteen-level path.
// Assumes: One byte per step; only data bytes are stepped in.
// Notes: Storage is flip-flops; shrink BRANCHES or UNIT for fast simulation.
`timescale 1ns/1ns
module vsbm_byte_ilv
   import vsbm_pkg::*;
#(
   parameter int BRANCHES = ILV_BRANCHES,
   parameter int UNIT = ILV_UNIT
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic step,
   input wire logic [7:0] din,
   output logic [7:0] dout
);
   localparam int TOTAL = UNIT * BRANCHES * (BRANCHES - 1) / 2;
   localparam int AW = $clog2(TOTAL);
   localparam int BW = $clog2(BRANCHES);
   localparam int PW = $clog2(UNIT * BRANCHES);
   typedef struct packed {
      logic [BW-1:0] br;
      logic [BRANCHES-1:0][PW-1:0] ptr;
      logic [TOTAL-1:0][7:0] mem;
   } vsbm_ilv_s;
   vsbm_ilv_s s_reg;
   vsbm_ilv_s s_next;
   logic [AW-1:0] addr;

   function automatic logic [AW-1:0] base_of(input logic [BW-1:0] b);
      int bi;
      bi = int'(b);
      return AW'(UNIT * bi * (bi - 1) / 2);
   endfunction

   always_comb begin
      s_next = s_reg;
      addr = base_of(s_reg.br) + AW'(s_reg.ptr[s_reg.br]);
      dout = (s_reg.br == '0) ? din : s_reg.mem[addr];
      if (step) begin
         if (s_reg.br != '0) begin
            s_next.mem[addr] = din;
            if (s_reg.ptr[s_reg.br] == PW'(UNIT * int'(s_reg.br) - 1)) begin
               s_next.ptr[s_reg.br] = '0;
            end else begin
               s_next.ptr[s_reg.br] = s_reg.ptr[s_reg.br] + 1'b1;
            end
         end
         s_next.br = (s_reg.br == BW'(BRANCHES - 1)) ? '0 : s_reg.br + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// ==== sim/vsbm_sink_model.sv ====
// Purpose: Downstream modulator model that accepts level-coded symbols.
// Assumes: Ready changes only at the falling edge of core_clk.
// Notes: Long stalls fill the two-entry buffer so back-pressure is exercised.
`timescale 1ns/1ns
module vsbm_sink_model (
   input wire logic core_clk,
   input wire logic slow,
   output logic out_ready
);
   integer seed = 30452;
   int cnt = 0;
   initial out_ready = 1'b1;
   // A slow sink stalls for 41 cycles in every 150, then accepts at random.
   always @(negedge core_clk) begin
      cnt <= cnt + 1;
      if (slow) begin
         out_ready <= (cnt % 150) > 40 && ($random(seed) % 3 != 0);
      end else begin
         out_ready <= 1'b1;
      end
   end
endmodule

// ==== sim/vsbm_mapper_test.sv ====
// Purpose: Self-checking bench for the symbol mapper with pilot.
// Assumes: Each reset starts an odd field with its field sync segment.
// Notes: A field is too long to reach the second field sync in one run.
`timescale 1ns/1ns
module vsbm_mapper_test;
   import vsbm_pkg::*;
   logic core_clk, rst, mode_16, enh_on, in_valid, in_ready, out_valid, out_ready;
   logic out_sync, out_seg_start, out_field_start, field_odd, slow;
   logic [1:0] ctx_num;
   logic [7:0] enh_bits, in_data, ilv_b;
   logic [LVL_W-1:0] out_level;
   logic [7:0] exp_q[$];
   logic [7:0] sent_q[$];
   integer seed = 30452;
   int failures = 0, n_tests = 0, idx = 0, seg_cnt = 0, lag = 0;
   bit fs, took;
   // A short interleaver and one slot every four clocks keep the run brief.
   localparam int ILV_B = 4;
   localparam int ILV_U = 1;

   vsbm_mapper #(.SYM_RATE_KHZ(12500), .BRANCHES(ILV_B), .UNIT(ILV_U)) vsbm_mapper_i (
      .core_clk(core_clk), .rst(rst), .mode_16(mode_16), .enh_on(enh_on),
      .ctx_num(ctx_num), .enh_bits(enh_bits), .in_valid(in_valid),
      .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
      .out_ready(out_ready), .out_level(out_level), .out_sync(out_sync),
      .out_seg_start(out_seg_start), .out_field_start(out_field_start),
      .field_odd(field_odd));
   vsbm_sink_model vsbm_sink_model_i (.core_clk(core_clk), .slow(slow), .out_ready(out_ready));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Levels are in quarters, with the pilot of the mode added.
   function automatic logic [7:0] lvl(input int nom);
      return 8'(nom * 4 + (mode_16 ? 10 : 5));
   endfunction

   function automatic logic [7:0] bin(input logic b);
      return lvl(b ? (mode_16 ? 9 : 5) : (mode_16 ? -9 : -5));
   endfunction

   function automatic logic enh_bit(input int k);
      logic [7:0] m;
      m = ENH_DEF_MASKS[8 * ctx_num +: 8];
      if (!enh_on) return 1'b0;
      if (k < 2) return ctx_num[1 - k];
      return enh_bits[k - 2] & m[k - 2];
   endfunction

   // The driver notes the levels each taken word must produce.
   always @(posedge core_clk) begin
      if (!rst && in_valid && in_ready) begin
         took = 1'b1;
         if (mode_16) begin
            // Branch b returns the byte taken b * ILV_U * ILV_B steps earlier, else zero.
            sent_q.push_back(in_data);
            lag = ILV_B * ILV_U * ((sent_q.size() - 1) % ILV_B);
            ilv_b = (sent_q.size() > lag) ? sent_q[sent_q.size() - 1 - lag] : 8'h00;
            exp_q.push_back(lvl(2 * int'(ilv_b[7:4]) - 15));
            exp_q.push_back(lvl(2 * int'(ilv_b[3:0]) - 15));
         end else begin
            exp_q.push_back(lvl(2 * int'(in_data[2:0]) - 7));
         end
      end
   end

   always @(negedge core_clk) begin
      if (took) begin
         in_data <= 8'($random(seed));
         took = 1'b0;
      end
   end

   // Each data symbol taken downstream is held against the oldest note of the driver.
   always @(posedge core_clk) begin
      if (rst) begin
         seg_cnt = 0;
      end else if (out_valid && out_ready) begin
         if (out_seg_start) begin
            if (seg_cnt > 0) check(8'(idx == 831), 8'h01);
            idx = 0;
            fs = out_field_start;
            seg_cnt++;
            if (seg_cnt == 1) check(8'(out_field_start & field_odd), 8'h01);
         end else begin
            idx++;
         end
         if (idx < 4) begin
            check(out_level, bin(idx == 0 || idx == 3));
            check(8'(out_sync), 8'h01);
         end else if (fs && idx >= 810 && idx < 820) begin
            check(out_level, bin(enh_bit(idx - 810)));
         end else if (fs && idx < 820) begin
            check(8'(out_level == bin(1) || out_level == bin(0)), 8'h01);
            check(8'(out_sync), 8'h01);
         end else if (!fs) begin
            check(8'(out_sync), 8'h00);
            check(8'(exp_q.size() > 0), 8'h01);
            if (exp_q.size() > 0) begin
               check(out_level, exp_q[0]);
            end
            if (exp_q.size() > 0) void'(exp_q.pop_front());
         end
      end
   end

   task automatic run_phase(input logic m16, input logic on, input logic [1:0] ctx,
                            input logic [7:0] bits, input logic stall);
      int n;
      rst = 1'b1;
      mode_16 = m16;
      enh_on = on;
      ctx_num = ctx;
      enh_bits = bits;
      slow = stall;
      in_data = 8'($random(seed));
      repeat (12) @(negedge core_clk);
      exp_q.delete();
      sent_q.delete();
      rst = 1'b0;
      n = 0;
      while (seg_cnt < 4 && n < 20000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 20000) begin
         failures++;
         end_sim();
      end
   endtask

   initial begin
      rst = 1'b1;
      mode_16 = 1'b0;
      enh_on = 1'b0;
      ctx_num = 2'h0;
      enh_bits = 8'h00;
      in_valid = 1'b1;
      in_data = 8'h00;
      slow = 1'b0;
      took = 1'b0;
      @(negedge core_clk);
      run_phase(1'b0, 1'b0, 2'h3, 8'hFF, 1'b0);
      run_phase(1'b0, 1'b1, 2'h1, 8'($random(seed)), 1'b1);
      run_phase(1'b0, 1'b1, 2'h2, 8'($random(seed)), 1'b0);
      run_phase(1'b0, 1'b1, 2'h0, 8'hFF, 1'b1);
      run_phase(1'b1, 1'b1, 2'h3, 8'($random(seed)), 1'b0);
      run_phase(1'b1, 1'b0, 2'h2, 8'hFF, 1'b1);
      end_sim();
   end
endmodule
